// ==== lat_addr_table.sv ====
// What this block does
// - Egress ports come from a destination_address table lookup, or from memberPorts on a miss.
// - Table holds management static entries and learned dynamic entries.
// - In auto mode only, source_address creates or refreshes a dynamic entry to ingress.
// - Dynamic entries unseen for the age time are removed.
// - Age time resets to three hundred seconds.
// - Age time accepts whole seconds from ten to ten million.
// - A control bit turns aging off; dynamic entries then stay.
// - Auto mode learns an unknown source_address at once if an entry is free and no staticWr falls in its lookup cycle.
// - Disabled mode neither creates nor refreshes entries from that port.
// - Secure mode passes only static source_address frames, drops others.
// - Mode writes are blocked while another function holds the port.
module lat_addr_table
    import lat_pkg::*;
#(
    parameter int unsigned PORTS = 8,
    parameter int unsigned ENTRIES = 16,
    parameter int unsigned AGE_SCAN = AGE_SCAN_DEFAULT
)(
    input wire logic clk,
    input wire logic nrst,
    input wire logic clkEn,
    input wire logic frameValid,
    input wire logic [ADDR_W-1:0] destination_address,
    input wire logic [ADDR_W-1:0] source_address,
    input wire logic [$clog2(PORTS)-1:0] ingressPort,
    input wire logic [PORTS-1:0] memberPorts,
    output logic frameReady,
    output logic fwdValid,
    output logic [PORTS-1:0] fwdPorts,
    output logic fwdDrop,
    input wire logic staticWr,
    input wire logic staticDel,
    input wire logic [ADDR_W-1:0] staticAddr,
    input wire logic [PORTS-1:0] staticPorts,
    input wire logic ageDisable,
    input wire logic ageWr,
    input wire logic [AGE_SW-1:0] ageTime,
    output logic [AGE_SW-1:0] ageTimeNow,
    input wire logic modeWr,
    input wire logic [$clog2(PORTS)-1:0] modePort,
    input wire logic [1:0] modeVal,
    input wire logic [PORTS-1:0] modeLocked,
    input wire logic [PORTS*2-1:0] lockedMode,
    output logic [PORTS*2-1:0] learnModeNow
);
    localparam int unsigned IW = $clog2(ENTRIES);
    localparam int unsigned PW = $clog2(PORTS);
    localparam int unsigned SCW = $clog2(AGE_SCAN + 1);

    logic [ENTRIES-1:0] vld_q, vld_d, stat_q, stat_d, hit_q, hit_d;
    logic [ADDR_W-1:0] key_q [ENTRIES], key_d [ENTRIES];
    logic [AGE_SW-1:0] idle_q [ENTRIES], idle_d [ENTRIES];
    logic [AGE_SW-1:0] age_q, age_d;
    logic [SCW-1:0] tick_q, tick_d;
    logic [PORTS*2-1:0] mode_q, mode_d;
    lat_state_t st_q, st_d;
    logic [ADDR_W-1:0] da_q, da_d, sa_q, sa_d;
    logic [PW-1:0] in_q, in_d;
    logic [PORTS-1:0] mem_q, mem_d, fp_q, fp_d, memWd, memRd;
    logic rdy_q, rdy_d, fv_q, fv_d, drop_q, drop_d, daHit_q, daHit_d;
    logic [ENTRIES-1:0] daM, saM, stM;
    logic [IW-1:0] daIdx, saIdx, stIdx, freeIdx, memWa;
    logic saFound, stFound, freeFound, memWr, second;
    logic [1:0] effMode;
    // Port lists live in RAM; only keys and flags need parallel compare
    lat_entry_mem #(.DEPTH(ENTRIES), .WIDTH(PORTS)) uMem (
        .clk(clk),
        .nrst(nrst),
        .en(clkEn),
        .rdAddr(daIdx),
        .rdData(memRd),
        .wrEn(memWr),
        .wrAddr(memWa),
        .wrData(memWd)
    );

    genvar g;
    generate
        for (g = 0; g < ENTRIES; g++)
        begin : gCmp
            assign daM[g] = vld_q[g] && key_q[g] == da_q;
            assign saM[g] = vld_q[g] && key_q[g] == sa_q;
            assign stM[g] = vld_q[g] && key_q[g] == staticAddr;
        end
    endgenerate

    always_comb
    begin
        daIdx = '0;
        saIdx = '0;
        stIdx = '0;
        freeIdx = '0;
        saFound = 1'b0;
        stFound = 1'b0;
        freeFound = 1'b0;
        for (int i = ENTRIES - 1; i >= 0; i--)
        begin
            if (daM[i])
                daIdx = IW'(i);
            if (saM[i])
            begin
                saIdx = IW'(i);
                saFound = 1'b1;
            end
            if (stM[i])
            begin
                stIdx = IW'(i);
                stFound = 1'b1;
            end
            if (!vld_q[i])
            begin
                freeIdx = IW'(i);
                freeFound = 1'b1;
            end
        end
        effMode = mode_q[in_q*2 +: 2];
        if (modeLocked[in_q])
            effMode = lockedMode[in_q*2 +: 2];
    end

    always_comb
    begin
        age_d = age_q;
        mode_d = mode_q;
        tick_d = tick_q + SCW'(1);
        second = tick_q == SCW'(AGE_SCAN - 1);
        if (second)
            tick_d = '0;
        // Out-of-range values are ignored rather than clamped
        if (ageWr && ageTime >= AGE_SW'(AGE_MIN_S) &&
            ageTime <= AGE_SW'(AGE_MAX_S))
            age_d = ageTime;
        for (int p = 0; p < PORTS; p++)
            if (modeWr && modePort == PW'(p) && !modeLocked[p])
                mode_d[p*2 +: 2] = modeVal;
    end

    always_comb
    begin
        st_d = st_q;
        da_d = da_q;
        sa_d = sa_q;
        in_d = in_q;
        mem_d = mem_q;
        rdy_d = rdy_q;
        fv_d = 1'b0;
        drop_d = drop_q;
        fp_d = fp_q;
        daHit_d = daHit_q;
        vld_d = vld_q;
        stat_d = stat_q;
        hit_d = hit_q;
        key_d = key_q;
        idle_d = idle_q;
        memWr = 1'b0;
        memWa = '0;
        memWd = '0;
        for (int i = 0; i < ENTRIES; i++)
        begin
            if (hit_q[i])
                idle_d[i] = '0;
            else if (second && !ageDisable && vld_q[i] && !stat_q[i])
            begin
                idle_d[i] = idle_q[i] + AGE_SW'(1);
                if (idle_q[i] + AGE_SW'(1) >= age_q)
                    vld_d[i] = 1'b0;
            end
            hit_d[i] = 1'b0;
        end
        if (staticWr)
        begin
            if (stFound || freeFound)
            begin
                memWr = 1'b1;
                memWa = stFound ? stIdx : freeIdx;
                memWd = staticPorts;
                vld_d[memWa] = 1'b1;
                stat_d[memWa] = 1'b1;
                key_d[memWa] = staticAddr;
                idle_d[memWa] = '0;
            end
        end
        else if (staticDel && stFound && stat_q[stIdx])
        begin
            vld_d[stIdx] = 1'b0;
            stat_d[stIdx] = 1'b0;
        end
        case (st_q)
            LAT_IDLE:
            begin
                rdy_d = 1'b1;
                if (frameValid && rdy_q)
                begin
                    da_d = destination_address;
                    sa_d = source_address;
                    in_d = ingressPort;
                    mem_d = memberPorts;
                    rdy_d = 1'b0;
                    st_d = LAT_LOOK;
                end
            end
            LAT_LOOK:
            begin
                daHit_d = |daM;
                drop_d = effMode == LEARN_SECURE &&
                    !(saFound && stat_q[saIdx]);
                if (effMode == LEARN_AUTO && !staticWr)
                begin
                    if (saFound && !stat_q[saIdx])
                    begin
                        memWr = 1'b1;
                        memWa = saIdx;
                        hit_d[saIdx] = 1'b1;
                        // A refresh outranks an age-out in the same cycle
                        vld_d[saIdx] = 1'b1;
                    end
                    else if (!saFound && freeFound)
                    begin
                        memWr = 1'b1;
                        memWa = freeIdx;
                        vld_d[freeIdx] = 1'b1;
                        stat_d[freeIdx] = 1'b0;
                        key_d[freeIdx] = sa_q;
                        idle_d[freeIdx] = '0;
                    end
                    memWd = PORTS'(1) << in_q;
                end
                st_d = LAT_ANS;
            end
            LAT_ANS:
            begin
                fv_d = 1'b1;
                fp_d = daHit_q ? memRd & ~(PORTS'(1) << in_q)
                    : mem_q & ~(PORTS'(1) << in_q);
                if (drop_q)
                    fp_d = '0;
                rdy_d = 1'b1;
                st_d = LAT_IDLE;
            end
            default: st_d = LAT_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            age_q <= AGE_SW'(AGE_DEFAULT_S);
            mode_q <= {PORTS{LEARN_RESET}};
            tick_q <= '0;
            st_q <= LAT_IDLE;
            da_q <= '0;
            sa_q <= '0;
            in_q <= '0;
            mem_q <= '0;
            rdy_q <= 1'b0;
            fv_q <= 1'b0;
            drop_q <= 1'b0;
            fp_q <= '0;
            daHit_q <= 1'b0;
            vld_q <= '0;
            stat_q <= '0;
            hit_q <= '0;
            key_q <= '{default: '0};
            idle_q <= '{default: '0};
        end
        else if (clkEn)
        begin
            age_q <= age_d;
            mode_q <= mode_d;
            tick_q <= tick_d;
            st_q <= st_d;
            da_q <= da_d;
            sa_q <= sa_d;
            in_q <= in_d;
            mem_q <= mem_d;
            rdy_q <= rdy_d;
            fv_q <= fv_d;
            drop_q <= drop_d;
            fp_q <= fp_d;
            daHit_q <= daHit_d;
            vld_q <= vld_d;
            stat_q <= stat_d;
            hit_q <= hit_d;
            key_q <= key_d;
            idle_q <= idle_d;
        end
    end

    assign frameReady = rdy_q;
    assign fwdValid = fv_q;
    assign fwdPorts = fp_q;
    assign fwdDrop = drop_q;
    assign ageTimeNow = age_q;
    assign learnModeNow = mode_q;
endmodule : lat_addr_table

// ==== lat_pkg.sv ====
package lat_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned AGE_DEFAULT_S = 300;
    localparam int unsigned AGE_MIN_S = 10;
    localparam int unsigned AGE_MAX_S = 10_000_000;
    localparam int unsigned AGE_SW = 24;
    localparam int unsigned AGE_SCAN_DEFAULT = CLK_HZ;
    localparam logic [1:0] LEARN_AUTO = 2'h0;
    localparam logic [1:0] LEARN_OFF = 2'h1;
    localparam logic [1:0] LEARN_SECURE = 2'h2;
    localparam logic [1:0] LEARN_RESET = LEARN_AUTO;
    localparam int unsigned ADDR_W = 48;
    typedef enum logic [1:0] {LAT_IDLE, LAT_LOOK, LAT_ANS} lat_state_t;
endpackage : lat_pkg

// ==== lat_entry_mem.sv ====
module lat_entry_mem
    import lat_pkg::*;
#(
    parameter int unsigned DEPTH = 16,
    parameter int unsigned WIDTH = 8
)(
    input wire logic clk,
    input wire logic nrst,
    input wire logic en,
    input wire logic [$clog2(DEPTH)-1:0] rdAddr,
    output logic [WIDTH-1:0] rdData,
    input wire logic wrEn,
    input wire logic [$clog2(DEPTH)-1:0] wrAddr,
    input wire logic [WIDTH-1:0] wrData
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] rdData_q;
    assign rdData = rdData_q;

    // Plain array with no reset so it maps to RAM
    always_ff @(posedge clk)
    begin
        if (en && wrEn)
        begin
            mem[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rdData_q <= '0;
        end
        else if (en)
        begin
            rdData_q <= mem[rdAddr];
        end
    end
endmodule : lat_entry_mem

// ==== lat_addr_table_properties.sv ====
module lat_addr_table_checker
    import lat_pkg::*;
#(
    parameter int unsigned PORTS = 8
)(
    input wire logic clk,
    input wire logic nrst,
    input wire logic frameValid,
    input wire logic [$clog2(PORTS)-1:0] ingressPort,
    input wire logic frameReady,
    input wire logic fwdValid,
    input wire logic [PORTS-1:0] fwdPorts,
    input wire logic fwdDrop,
    input wire logic ageWr,
    input wire logic [AGE_SW-1:0] ageTime,
    input wire logic [AGE_SW-1:0] ageTimeNow,
    input wire logic modeWr,
    input wire logic [$clog2(PORTS)-1:0] modePort,
    input wire logic [PORTS-1:0] modeLocked,
    input wire logic [PORTS*2-1:0] learnModeNow
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_ans;
        frameValid && frameReady |-> ##3 fwdValid;
    endproperty
    a_ans: assert property (p_ans) else $error("answer late");
    property p_busy;
        frameValid && frameReady |=> !frameReady [*2] ##1 frameReady;
    endproperty
    a_busy: assert property (p_busy) else $error("ready wrong");
    property p_pulse;
        fwdValid |=> !fwdValid;
    endproperty
    a_pulse: assert property (p_pulse) else $error("valid long");
    property p_ingress;
        fwdValid |-> !fwdPorts[$past(ingressPort, 3)];
    endproperty
    a_ingress: assert property (p_ingress) else $error("echo");
    property p_drop;
        fwdValid && fwdDrop |-> fwdPorts == '0;
    endproperty
    a_drop: assert property (p_drop) else $error("drop fwd");
    property p_ageHold;
        !$past(ageWr) |-> $stable(ageTimeNow);
    endproperty
    a_ageHold: assert property (p_ageHold) else $error("age moved");
    property p_ageLoad;
        $past(ageWr) && $past(ageTime) >= AGE_MIN_S
            && $past(ageTime) <= AGE_MAX_S |-> ageTimeNow == $past(ageTime);
    endproperty
    a_ageLoad: assert property (p_ageLoad) else $error("age load");
    property p_lock;
        modeWr && modeLocked[modePort] |=> $stable(learnModeNow);
    endproperty
    a_lock: assert property (p_lock) else $error("locked write");
endmodule : lat_addr_table_checker

bind lat_addr_table lat_addr_table_checker #(.PORTS(PORTS)) chk (.clk,
    .nrst, .frameValid, .ingressPort, .frameReady, .fwdValid, .fwdPorts,
    .fwdDrop, .ageWr, .ageTime, .ageTimeNow, .modeWr, .modePort,
    .modeLocked, .learnModeNow);

// ==== lat_ingress_model.sv ====
module lat_ingress_model
    import lat_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic go,
    input wire logic [ADDR_W-1:0] reqDa,
    input wire logic [ADDR_W-1:0] reqSa,
    input wire logic [2:0] reqPort,
    input wire logic frameReady,
    output logic frameValid,
    output logic [ADDR_W-1:0] destination_address,
    output logic [ADDR_W-1:0] source_address,
    output logic [2:0] ingressPort
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            frameValid <= 1'b0;
            destination_address <= '0;
            source_address <= '0;
            ingressPort <= '0;
        end
        else if (go)
        begin
            frameValid <= 1'b1;
            destination_address <= reqDa;
            source_address <= reqSa;
            ingressPort <= reqPort;
        end
        else if (frameValid && frameReady)
        begin
            // Inverted once taken, so stale fields never pass for valid
            frameValid <= 1'b0;
            destination_address <= ~destination_address;
            source_address <= ~source_address;
            ingressPort <= ~ingressPort;
        end
    end
endmodule : lat_ingress_model

// ==== tb.sv ====
module tb
    import lat_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [7:0] da; logic [7:0] sa; logic [2:0] p;
        logic [7:0] exp;} lat_row_t;
    lat_row_t rows [3] = '{'{8'h0A, 8'h0B, 3'h1, 8'hFD},
        '{8'h0B, 8'h0A, 3'h2, 8'h02}, '{8'h0A, 8'h0C, 3'h3, 8'h04}};
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic go = 1'b0;
    logic frameValid, frameReady, fwdValid, fwdDrop;
    logic [47:0] reqDa = '0, reqSa = '0, destination_address, source_address;
    logic [47:0] staticAddr = '0;
    logic [2:0] reqPort = '0, ingressPort, modePort = '0;
    logic [7:0] fwdPorts, staticPorts = '0, modeLocked = '0;
    logic [7:0] memberPorts = 8'hFF;
    logic staticWr = 0, staticDel = 0, ageDisable = 0, ageWr = 0, modeWr = 0;
    logic [23:0] ageTime = '0, ageTimeNow;
    logic [1:0] modeVal = '0;
    logic [15:0] lockedMode = '0, learnModeNow;
    int miscompares = 0, tests_run = 0;
    always #10 clk = ~clk;
    lat_ingress_model src (.clk, .nrst, .go, .reqDa, .reqSa, .reqPort,
        .frameReady, .frameValid, .destination_address, .source_address,
        .ingressPort);
    // Ten cycles per second keeps the aging waits short
    lat_addr_table #(.AGE_SCAN(10)) uut (.clk, .nrst, .clkEn(1'b1),
        .frameValid, .destination_address, .source_address, .ingressPort,
        .memberPorts, .frameReady, .fwdValid, .fwdPorts, .fwdDrop,
        .staticWr, .staticDel, .staticAddr, .staticPorts, .ageDisable,
        .ageWr, .ageTime, .ageTimeNow, .modeWr, .modePort, .modeVal,
        .modeLocked, .lockedMode, .learnModeNow);
    function automatic logic [47:0] mac(input logic [7:0] n);
        return {8'h02, 32'h0000_0000, n};
    endfunction : mac
    task automatic cmpFwd(input logic [9:0] e);
        tests_run++;
        if ({fwdValid, fwdDrop, fwdPorts} !== e)
        begin
            miscompares++;
            $display("MISMATCH %0t fwd %h exp %h", $time,
                {fwdValid, fwdDrop, fwdPorts}, e);
        end
    endtask : cmpFwd
    task automatic cmpVal(input logic [23:0] g, input logic [23:0] e);
        tests_run++;
        if (g !== e)
        begin
            miscompares++;
            $display("MISMATCH %0t value %h exp %h", $time, g, e);
        end
    endtask : cmpVal
    task automatic frame(input logic [7:0] da, input logic [7:0] sa,
        input logic [2:0] p, input logic [8:0] e);
        int n = 0;
        reqDa <= mac(da);
        reqSa <= mac(sa);
        reqPort <= p;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        while (fwdValid !== 1'b1 && n < 12)
        begin
            @(posedge clk);
            n++;
        end
        cmpFwd({1'b1, e});
    endtask : frame
    task automatic mgmt(input int k);
        staticWr <= (k == 0);
        staticDel <= (k == 1);
        ageWr <= (k == 2);
        modeWr <= (k == 3);
        @(posedge clk);
        {staticWr, staticDel, ageWr, modeWr} <= '0;
        @(posedge clk);
    endtask : mgmt
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        repeat (3000) @(posedge clk);
        miscompares++;
        tally_and_finish();
    end
    initial
    begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        cmpVal(ageTimeNow, 24'h00_012C);
        cmpVal({8'h00, learnModeNow}, 24'h00_0000);
        foreach (rows[i])
            frame(rows[i].da, rows[i].sa, rows[i].p,
                {1'b0, rows[i].exp});
        ageTime <= 24'h00_0009;
        mgmt(2);
        cmpVal(ageTimeNow, 24'h00_012C);
        ageTime <= 24'h98_9681;
        mgmt(2);
        cmpVal(ageTimeNow, 24'h00_012C);
        ageTime <= 24'h00_000A;
        mgmt(2);
        cmpVal(ageTimeNow, 24'h00_000A);
        staticAddr <= mac(8'h0D);
        staticPorts <= 8'h80;
        mgmt(0);
        frame(8'h0D, 8'h0D, 3'h0, 9'h080);
        repeat (130) @(posedge clk);
        frame(8'h0A, 8'h0D, 3'h3, 9'h0F7);
        frame(8'h0D, 8'h0D, 3'h0, 9'h080);
        frame(8'h0D, 8'h0E, 3'h4, 9'h080);
        ageDisable <= 1'b1;
        repeat (130) @(posedge clk);
        frame(8'h0E, 8'h0D, 3'h0, 9'h010);
        modePort <= 3'h5;
        modeVal <= LEARN_OFF;
        mgmt(3);
        frame(8'h0D, 8'h0F, 3'h5, 9'h080);
        frame(8'h0F, 8'h0D, 3'h0, 9'h0FE);
        modePort <= 3'h6;
        modeVal <= LEARN_SECURE;
        mgmt(3);
        frame(8'h0D, 8'h07, 3'h6, 9'h100);
        frame(8'h0E, 8'h0D, 3'h6, 9'h010);
        frame(8'h07, 8'h0D, 3'h0, 9'h0FE);
        modeLocked <= 8'h80;
        modePort <= 3'h7;
        mgmt(3);
        cmpVal({8'h00, learnModeNow}, 24'h00_2400);
        lockedMode <= 16'h8000;
        frame(8'h0E, 8'h12, 3'h7, 9'h100);
        mgmt(1);
        frame(8'h0D, 8'h0E, 3'h4, 9'h0EF);
        memberPorts <= 8'h3C;
        frame(8'h0F, 8'h0E, 3'h2, 9'h038);
        tally_and_finish();
    end
endmodule : tb
